// ---- logic/dss_pkg.sv ----
package dss_pkg;
    localparam int unsigned data_w = 32;
    localparam int unsigned addr_w = 8;
    // register byte addresses (printed index times four where needed)
    localparam logic [7:0] status_index = 8'h02;
    localparam logic [7:0] status_addr = 8'h08;
    localparam logic [7:0] blk_over_th_addr = 8'h10;
    localparam logic [7:0] blk_under_th_addr = 8'h14;
    localparam logic [7:0] irq_status_addr = 8'h18;
    localparam logic [7:0] irq_mask_addr = 8'h1c;
    localparam logic [7:0] sources_addr = 8'h20;
    // field positions of the summary register
    localparam int unsigned bit_scan = 15;
    localparam int unsigned bit_rst = 14;
    localparam int unsigned bit_mismatch = 13;
    localparam int unsigned bit_cell_ov = 12;
    localparam int unsigned bit_cell_uv = 11;
    localparam int unsigned bit_blk_ov = 10;
    localparam int unsigned bit_blk_uv = 9;
    localparam int unsigned bit_aux_ov = 8;
    localparam int unsigned bit_aux_uv = 7;
    localparam int unsigned bit_unused = 6;
    localparam int unsigned bit_pec = 5;
    localparam int unsigned bit_intrfc = 4;
    localparam int unsigned bit_cal = 3;
    localparam int unsigned bit_cbal = 2;
    localparam int unsigned bit_fmea2 = 1;
    localparam int unsigned bit_fmea1 = 0;
    // reset values
    localparam logic [15:0] status_reset = 16'h4000;
    localparam logic [15:0] blk_th_reset = 16'h0000;
    localparam logic [7:0] irq_reset = 8'h00;
    localparam int unsigned n_events = 8;
endpackage

// ---- logic/dss_evt_if.sv ----
`timescale 1ns/1ns
// sticky event bank link between the register file and event logic
interface dss_evt_if #(parameter int unsigned n = 8);
    logic [n-1:0] evt;
    logic [n-1:0] clr;
    logic [n-1:0] mask;
    logic [n-1:0] flags;
    logic irq;
    modport owner (output evt, output clr, output mask,
        input flags, input irq);
    modport bank (input evt, input clr, input mask,
        output flags, output irq);
endinterface

// ---- logic/dss_irq_bank.sv ----
`timescale 1ns/1ns
// sticky event flags; a set in the same cycle as a clear wins
module dss_irq_bank (
    input wire logic pclk,
    input wire logic presetn,
    dss_evt_if.bank ev
);
    logic [dss_pkg::n_events-1:0] flags_q;
    logic irq_q;

    // set dominates clear so no event is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= dss_pkg::irq_reset;
        end else begin
            flags_q <= (flags_q & ~ev.clr) | ev.evt;
        end
    end

    // level interrupt, registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(((flags_q & ~ev.clr) | ev.evt) & ev.mask);
        end
    end

    assign ev.flags = flags_q;
    assign ev.irq = irq_q;
endmodule

// ---- logic/dss_status.sv ----
`timescale 1ns/1ns
module dss_status #(
    parameter int unsigned cells = 14,
    parameter int unsigned auxes = 6,
    parameter int unsigned vw = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scan_complete_flag,
    input wire logic cell_acq_done,
    input wire logic [vw-1:0] cell_max,
    input wire logic [vw-1:0] cell_min,
    input wire logic [vw-1:0] mismatch_threshold,
    input wire logic [cells:1] adc_cell_over_alerts,
    input wire logic [cells:1] comparator_cell_over_alerts,
    input wire logic [cells:1] adc_cell_under_alerts,
    input wire logic [cells:1] comparator_cell_under_alerts,
    input wire logic [auxes-1:0] adc_aux_over_alerts,
    input wire logic [auxes-1:0] comparator_aux_over_alerts,
    input wire logic [auxes-1:0] adc_aux_under_alerts,
    input wire logic [auxes-1:0] comparator_aux_under_alerts,
    input wire logic block_acq_done,
    input wire logic [vw-1:0] block_voltage,
    input wire logic up_path_checksum_alert,
    input wire logic down_path_checksum_alert,
    input wire logic interface_error_alert,
    input wire logic calibration_fault_alert,
    input wire logic balancing_alert,
    input wire logic [15:0] fault_group_two,
    input wire logic [15:0] fault_group_one,
    output logic irq
);
    logic [15:0] stat_q;
    logic [vw-1:0] blk_ov_th_q;
    logic [vw-1:0] blk_uv_th_q;
    logic [7:0] mask_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic setup;
    logic wr;
    logic rst_clr;
    logic any_ov;
    logic any_uv;
    logic aux_ov;
    logic aux_uv;
    logic mism;
    logic [15:0] stat_d;
    logic [15:0] stat_rise;
    logic [7:0] evt_bits;
    logic [7:0] clr_bits;
    logic mapped;

    dss_evt_if #(.n(dss_pkg::n_events)) ev ();

    // setup phase selects the read data; a write lands only in the
    // access phase, at the edge where pready is seen high
    assign setup = psel && !penable;
    assign wr = psel && penable && pready_q && pwrite;
    assign mapped = (paddr == dss_pkg::status_addr)
        || (paddr == dss_pkg::blk_over_th_addr)
        || (paddr == dss_pkg::blk_under_th_addr)
        || (paddr == dss_pkg::irq_status_addr)
        || (paddr == dss_pkg::irq_mask_addr)
        || (paddr == dss_pkg::sources_addr);
    // only a written 0 in bit 14 clears; a written 1 does nothing
    assign rst_clr = wr && (paddr == dss_pkg::status_addr)
        && !pwdata[dss_pkg::bit_rst];

    // live summaries of the alert sources
    assign any_ov = |adc_cell_over_alerts
        || |comparator_cell_over_alerts;
    assign any_uv = |adc_cell_under_alerts
        || |comparator_cell_under_alerts;
    assign aux_ov = |adc_aux_over_alerts
        || |comparator_aux_over_alerts;
    assign aux_uv = |adc_aux_under_alerts || |comparator_aux_under_alerts;
    assign mism = (cell_max > cell_min)
        && ((cell_max - cell_min) > mismatch_threshold);

    // next value of the summary register
    always_comb begin
        stat_d = stat_q;
        stat_d[dss_pkg::bit_scan] = scan_complete_flag;
        if (rst_clr) begin
            stat_d[dss_pkg::bit_rst] = 1'b0;
        end
        // a set from the source wins over a clear at acquisition
        if (any_ov) begin
            stat_d[dss_pkg::bit_cell_ov] = 1'b1;
        end else if (cell_acq_done) begin
            stat_d[dss_pkg::bit_cell_ov] = 1'b0;
        end
        if (any_uv) begin
            stat_d[dss_pkg::bit_cell_uv] = 1'b1;
        end else if (cell_acq_done) begin
            stat_d[dss_pkg::bit_cell_uv] = 1'b0;
        end
        if (aux_ov) begin
            stat_d[dss_pkg::bit_aux_ov] = 1'b1;
        end else if (cell_acq_done) begin
            stat_d[dss_pkg::bit_aux_ov] = 1'b0;
        end
        if (aux_uv) begin
            stat_d[dss_pkg::bit_aux_uv] = 1'b1;
        end else if (cell_acq_done) begin
            stat_d[dss_pkg::bit_aux_uv] = 1'b0;
        end
        if (cell_acq_done) begin
            stat_d[dss_pkg::bit_mismatch] = mism;
        end
        // block alerts only move at a block acquisition
        if (block_acq_done) begin
            stat_d[dss_pkg::bit_blk_ov] =
                block_voltage > blk_ov_th_q;
            stat_d[dss_pkg::bit_blk_uv] =
                block_voltage < blk_uv_th_q;
        end
        stat_d[dss_pkg::bit_unused] = 1'b0;
        stat_d[dss_pkg::bit_pec] = up_path_checksum_alert
            || down_path_checksum_alert;
        // summaries of the other registers follow their sources
        stat_d[dss_pkg::bit_intrfc] = interface_error_alert;
        stat_d[dss_pkg::bit_cal] = calibration_fault_alert;
        stat_d[dss_pkg::bit_cbal] = balancing_alert;
        stat_d[dss_pkg::bit_fmea2] = |fault_group_two;
        stat_d[dss_pkg::bit_fmea1] = |fault_group_one;
    end

    // summary register; the reset-alert bit powers up set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= dss_pkg::status_reset;
        end else begin
            stat_q <= stat_d;
        end
    end

    // block thresholds written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blk_ov_th_q <= vw'(dss_pkg::blk_th_reset);
            blk_uv_th_q <= vw'(dss_pkg::blk_th_reset);
        end else if (wr) begin
            if (paddr == dss_pkg::blk_over_th_addr) begin
                blk_ov_th_q <= pwdata[vw-1:0];
            end
            if (paddr == dss_pkg::blk_under_th_addr) begin
                blk_uv_th_q <= pwdata[vw-1:0];
            end
        end
    end

    // interrupt mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= dss_pkg::irq_reset;
        end else if (wr && paddr == dss_pkg::irq_mask_addr) begin
            mask_q <= pwdata[7:0];
        end
    end

    // events are rising edges of the high byte of the summary
    assign stat_rise = stat_d & ~stat_q;
    assign evt_bits = stat_rise[15:8];
    assign clr_bits = (wr && paddr == dss_pkg::irq_status_addr)
        ? pwdata[7:0] : 8'h00;
    assign ev.evt = evt_bits;
    assign ev.clr = clr_bits;
    assign ev.mask = mask_q;

    dss_irq_bank u_bank (
        .pclk(pclk),
        .presetn(presetn),
        .ev(ev)
    );

    // apb answer: no wait state, pready high in the first access cycle, read data captured in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup && !mapped;
            if (setup && !pwrite) begin
                case (paddr)
                    dss_pkg::status_addr: prdata_q <= {16'h0000, stat_q};
                    dss_pkg::blk_over_th_addr:
                        prdata_q <= 32'(blk_ov_th_q);
                    dss_pkg::blk_under_th_addr:
                        prdata_q <= 32'(blk_uv_th_q);
                    dss_pkg::irq_status_addr:
                        prdata_q <= {24'h000000, ev.flags};
                    dss_pkg::irq_mask_addr:
                        prdata_q <= {24'h000000, mask_q};
                    dss_pkg::sources_addr:
                        prdata_q <= {28'h0000000, any_ov, any_uv,
                            aux_ov, mism};
                    default: prdata_q <= 32'h00000000;
                endcase
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = ev.irq;

    // reset alert stays set across writes of one
    property p_rst_hold;
        @(posedge pclk) disable iff (!presetn)
        (stat_q[dss_pkg::bit_rst] && !rst_clr)
        |=> stat_q[dss_pkg::bit_rst];
    endproperty
    a_rst_hold: assert property (p_rst_hold)
        else $error("reset alert lost without a zero write");

    property p_rst_clr;
        @(posedge pclk) disable iff (!presetn)
        rst_clr |=> !stat_q[dss_pkg::bit_rst];
    endproperty
    a_rst_clr: assert property (p_rst_clr)
        else $error("reset alert not cleared by zero write");

    property p_scan;
        @(posedge pclk) disable iff (!presetn)
        ##1 (stat_q[dss_pkg::bit_scan] == $past(scan_complete_flag));
    endproperty
    a_scan: assert property (p_scan)
        else $error("scan alert does not follow scan flag");

    property p_cell_ov;
        @(posedge pclk) disable iff (!presetn)
        any_ov |=> stat_q[dss_pkg::bit_cell_ov];
    endproperty
    a_cell_ov: assert property (p_cell_ov)
        else $error("cell over summary missed");

    property p_cell_ov_hold;
        @(posedge pclk) disable iff (!presetn)
        (stat_q[dss_pkg::bit_cell_ov] && !cell_acq_done)
        |=> stat_q[dss_pkg::bit_cell_ov];
    endproperty
    a_cell_ov_hold: assert property (p_cell_ov_hold)
        else $error("cell over summary dropped between acquisitions");

    property p_cell_uv;
        @(posedge pclk) disable iff (!presetn)
        (any_uv or (stat_q[dss_pkg::bit_cell_uv] && !cell_acq_done))
        |=> stat_q[dss_pkg::bit_cell_uv];
    endproperty
    a_cell_uv: assert property (p_cell_uv)
        else $error("cell under summary wrong");

    property p_blk;
        @(posedge pclk) disable iff (!presetn)
        !block_acq_done |=> $stable(stat_q[dss_pkg::bit_blk_ov])
            && $stable(stat_q[dss_pkg::bit_blk_uv]);
    endproperty
    a_blk: assert property (p_blk)
        else $error("block alert moved without acquisition");

    property p_blk_ov;
        @(posedge pclk) disable iff (!presetn)
        (block_acq_done && block_voltage > blk_ov_th_q)
        |=> stat_q[dss_pkg::bit_blk_ov];
    endproperty
    a_blk_ov: assert property (p_blk_ov)
        else $error("block over alert missed");

    property p_unused;
        @(posedge pclk) disable iff (!presetn)
        !stat_q[dss_pkg::bit_unused];
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused bit set");

    property p_pec;
        @(posedge pclk) disable iff (!presetn)
        (up_path_checksum_alert || down_path_checksum_alert)
        |=> stat_q[dss_pkg::bit_pec];
    endproperty
    a_pec: assert property (p_pec)
        else $error("checksum alert missed");

    // a setup phase is answered by a single pready pulse
    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_pulse;
        pready ##1 !pready;
    endsequence

    property p_answer;
        @(posedge pclk) disable iff (!presetn)
        s_setup |=> s_pulse;
    endproperty
    a_answer: assert property (p_answer)
        else $error("apb request not answered by one pready pulse");

    property p_mism;
        @(posedge pclk) disable iff (!presetn)
        cell_acq_done |=> (stat_q[dss_pkg::bit_mismatch] == $past(mism));
    endproperty
    a_mism: assert property (p_mism)
        else $error("mismatch alert not refreshed at acquisition");

    property p_blk_uv;
        @(posedge pclk) disable iff (!presetn)
        (block_acq_done && block_voltage < blk_uv_th_q)
        |=> stat_q[dss_pkg::bit_blk_uv];
    endproperty
    a_blk_uv: assert property (p_blk_uv)
        else $error("block under alert missed");

    property p_aux_ov;
        @(posedge pclk) disable iff (!presetn)
        aux_ov |=> stat_q[dss_pkg::bit_aux_ov];
    endproperty
    a_aux_ov: assert property (p_aux_ov)
        else $error("aux over summary missed");

    property p_fault_sum;
        @(posedge pclk) disable iff (!presetn)
        (|fault_group_one) |=> stat_q[dss_pkg::bit_fmea1];
    endproperty
    a_fault_sum: assert property (p_fault_sum)
        else $error("fault group summary missed");

    // the interrupt pin tracks the sticky flags under last cycle's mask
    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        ##1 (irq == |(ev.flags & $past(mask_q)));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt does not match masked flags");
endmodule

// ---- tb/tb_device_status_summary_register.sv ----
`timescale 1ns/1ns
module tb_device_status_summary_register;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, sl;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic scan_complete_flag, cell_acq_done, block_acq_done;
    logic [15:0] cell_max, cell_min, mismatch_threshold, block_voltage;
    logic [14:1] adc_cell_over_alerts, comparator_cell_over_alerts;
    logic [14:1] adc_cell_under_alerts, comparator_cell_under_alerts;
    logic [5:0] adc_aux_over_alerts, comparator_aux_over_alerts;
    logic [5:0] adc_aux_under_alerts, comparator_aux_under_alerts;
    logic up_path_checksum_alert, down_path_checksum_alert;
    logic interface_error_alert, calibration_fault_alert, balancing_alert;
    logic [15:0] fault_group_two, fault_group_one;
    int err_count = 0;
    int checked = 0;
    int b;
    int mb[11] = '{8, 8, 5, 5, 4, 3, 2, 1, 0, 7, 7};

    dss_status dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .scan_complete_flag,
        .cell_acq_done, .cell_max, .cell_min, .mismatch_threshold,
        .adc_cell_over_alerts, .comparator_cell_over_alerts,
        .adc_cell_under_alerts, .comparator_cell_under_alerts,
        .adc_aux_over_alerts, .comparator_aux_over_alerts,
        .adc_aux_under_alerts, .comparator_aux_under_alerts,
        .block_acq_done, .block_voltage, .up_path_checksum_alert,
        .down_path_checksum_alert, .interface_error_alert,
        .calibration_fault_alert, .balancing_alert, .fault_group_two,
        .fault_group_one, .irq);

    // free-running 25 MHz clock
    always #20 pclk = ~pclk;

    task wrap_up;
        $display("mismatches=%0d comparisons=%0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; read data and error taken at the pready edge
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait for pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        sl = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task stat_bit(input int i, input logic e);
        xfer(dss_pkg::status_addr, 1'b0, 32'h0);
        chk({31'h0, rd[i]}, {31'h0, e});
    endtask

    // irq is registered; look at it mid-cycle once it has settled
    task irq_is(input logic e);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk({31'h0, irq}, {31'h0, e});
    endtask

    task pulse(input logic blk);
        @(posedge pclk);
        if (blk) block_acq_done <= 1'b1;
        else cell_acq_done <= 1'b1;
        @(posedge pclk);
        block_acq_done <= 1'b0;
        cell_acq_done <= 1'b0;
    endtask

    task set_cell(input int k, input logic [14:1] v);
        case (k)
            0: adc_cell_over_alerts <= v;
            1: comparator_cell_over_alerts <= v;
            2: adc_cell_under_alerts <= v;
            default: comparator_cell_under_alerts <= v;
        endcase
    endtask

    task set_misc(input int k, input logic v);
        case (k)
            0: adc_aux_over_alerts <= {v, 5'h00};
            1: comparator_aux_over_alerts <= {5'h00, v};
            2: up_path_checksum_alert <= v;
            3: down_path_checksum_alert <= v;
            4: interface_error_alert <= v;
            5: calibration_fault_alert <= v;
            6: balancing_alert <= v;
            7: fault_group_two <= {v, 15'h0000};
            8: fault_group_one <= {15'h0000, v};
            9: adc_aux_under_alerts <= {v, 5'h00};
            default: comparator_aux_under_alerts <= {5'h00, v};
        endcase
    endtask

    // a hung handshake ends the run long after the tests should be done
    initial begin
        #400000;
        err_count++;
        wrap_up;
    end

    initial begin
        {pclk, presetn, psel, penable, pwrite, scan_complete_flag} = 6'h00;
        {cell_acq_done, block_acq_done, up_path_checksum_alert} = 3'h0;
        {down_path_checksum_alert, interface_error_alert} = 2'h0;
        {calibration_fault_alert, balancing_alert} = 2'h0;
        {paddr, pwdata} = 40'h0;
        {cell_max, cell_min, mismatch_threshold, block_voltage} = 64'h0;
        {fault_group_two, fault_group_one} = 32'h0;
        {adc_cell_over_alerts, comparator_cell_over_alerts} = 28'h0;
        {adc_cell_under_alerts, comparator_cell_under_alerts} = 28'h0;
        {adc_aux_over_alerts, comparator_aux_over_alerts} = 12'h0;
        {adc_aux_under_alerts, comparator_aux_under_alerts} = 12'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        xfer(dss_pkg::status_addr, 1'b0, 32'h0);
        chk(rd, 32'h0000_4000);
        xfer(dss_pkg::status_addr, 1'b1, 32'hffff_ffff);
        xfer(dss_pkg::status_addr, 1'b0, 32'h0);
        chk(rd, 32'h0000_4000);
        xfer(dss_pkg::status_addr, 1'b1, 32'hffff_bfff);
        xfer(dss_pkg::status_addr, 1'b0, 32'h0);
        chk(rd, 32'h0000_0000);
        scan_complete_flag <= 1'b1;
        stat_bit(dss_pkg::bit_scan, 1'b1);
        scan_complete_flag <= 1'b0;
        stat_bit(dss_pkg::bit_scan, 1'b0);
        // spread equal to the threshold must not count as a mismatch
        cell_max <= 16'd200;
        cell_min <= 16'd100;
        mismatch_threshold <= 16'd100;
        pulse(1'b0);
        stat_bit(dss_pkg::bit_mismatch, 1'b0);
        mismatch_threshold <= 16'd99;
        stat_bit(dss_pkg::bit_mismatch, 1'b0);
        pulse(1'b0);
        stat_bit(dss_pkg::bit_mismatch, 1'b1);
        mismatch_threshold <= 16'd100;
        stat_bit(dss_pkg::bit_mismatch, 1'b1);
        pulse(1'b0);
        stat_bit(dss_pkg::bit_mismatch, 1'b0);
        // summary must hold while any one source is still active
        set_cell(0, 14'h0001);
        set_cell(1, 14'h2000);
        @(posedge pclk);
        set_cell(0, 14'h0000);
        pulse(1'b0);
        stat_bit(dss_pkg::bit_cell_ov, 1'b1);
        xfer(dss_pkg::sources_addr, 1'b0, 32'h0);
        chk(rd, 32'h0000_0008);
        set_cell(1, 14'h0000);
        pulse(1'b0);
        stat_bit(dss_pkg::bit_cell_ov, 1'b0);
        for (int k = 0; k < 4; k++) begin
            b = (k < 2) ? dss_pkg::bit_cell_ov : dss_pkg::bit_cell_uv;
            set_cell(k, (k % 2 == 0) ? 14'h2000 : 14'h0001);
            stat_bit(b, 1'b1);
            set_cell(k, 14'h0000);
            stat_bit(b, 1'b1);
            pulse(1'b0);
            stat_bit(b, 1'b0);
        end
        xfer(dss_pkg::blk_over_th_addr, 1'b1, 32'd100);
        xfer(dss_pkg::blk_under_th_addr, 1'b1, 32'd50);
        xfer(dss_pkg::blk_over_th_addr, 1'b0, 32'h0);
        chk(rd, 32'd100);
        xfer(dss_pkg::blk_under_th_addr, 1'b0, 32'h0);
        chk(rd, 32'd50);
        block_voltage <= 16'd101;
        stat_bit(dss_pkg::bit_blk_ov, 1'b0);
        pulse(1'b1);
        stat_bit(dss_pkg::bit_blk_ov, 1'b1);
        stat_bit(dss_pkg::bit_blk_uv, 1'b0);
        block_voltage <= 16'd100;
        pulse(1'b0);
        stat_bit(dss_pkg::bit_blk_ov, 1'b1);
        pulse(1'b1);
        stat_bit(dss_pkg::bit_blk_ov, 1'b0);
        // interrupt: flag of block over sits at irq bit 2, masked out so far
        xfer(dss_pkg::irq_status_addr, 1'b0, 32'h0);
        chk(rd & 32'h4, 32'h4);
        irq_is(1'b0);
        xfer(dss_pkg::irq_mask_addr, 1'b1, 32'h4);
        xfer(dss_pkg::irq_mask_addr, 1'b0, 32'h0);
        chk(rd, 32'h4);
        irq_is(1'b1);
        xfer(dss_pkg::irq_status_addr, 1'b1, 32'h4);
        irq_is(1'b0);
        block_voltage <= 16'd49;
        pulse(1'b1);
        stat_bit(dss_pkg::bit_blk_uv, 1'b1);
        irq_is(1'b0);
        xfer(dss_pkg::irq_status_addr, 1'b0, 32'h0);
        chk(rd & 32'h6, 32'h2);
        block_voltage <= 16'd50;
        pulse(1'b1);
        stat_bit(dss_pkg::bit_blk_uv, 1'b0);
        // sticky summaries need an acquisition to clear; others just follow
        for (int k = 0; k < 11; k++) begin
            set_misc(k, 1'b1);
            stat_bit(mb[k], 1'b1);
            set_misc(k, 1'b0);
            pulse(1'b0);
            stat_bit(mb[k], 1'b0);
        end
        // unmapped place: refused, write dropped, read zero
        xfer(8'h44, 1'b1, 32'hffff_ffff);
        chk({31'h0, sl}, 32'h1);
        xfer(8'h44, 1'b0, 32'h0);
        chk(rd, 32'h0);
        wrap_up;
    end
endmodule
